// file: verilog/cmps_pkg.sv
package cmps_pkg;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 8;
   localparam int WAIT_MS_NS = 1000000;
   localparam int CYCLES_PER_MS_DEF = WAIT_MS_NS / CLK_PERIOD_NS;
   localparam int MS_PER_S = 1000;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_WAIT = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h0C;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h10;

   // ----------------------------------------------------------------
   // Control fields
   // ----------------------------------------------------------------
   localparam int CTRL_MODE_LSB = 0;
   localparam int MODE_W = 2;
   localparam int CTRL_COUNT_LSB = 8;
   localparam int COUNT_W = 5;
   localparam int CTRL_RESTART_BIT = 16;
   localparam int CTRL_UNIT_BIT = 20;
   localparam int CTRL_STOPM_LSB = 24;
   localparam int STOPM_W = 2;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [1:0] MODE_CYCLIC = 2'h1;
   localparam logic [4:0] COUNT_MAX = 5'h10;
   localparam int IDX_W = 4;
   localparam int WAIT_W = 16;
   localparam logic [15:0] WAIT_RESET = 16'h0000;

   // ----------------------------------------------------------------
   // Status and interrupt fields
   // ----------------------------------------------------------------
   localparam int STAT_STATE_LSB = 0;
   localparam int STAT_IDX_LSB = 4;
   localparam int STAT_DONE_BIT = 8;
   localparam int STAT_DIR_BIT = 9;
   localparam int IRQ_W = 3;
   localparam int IRQ_MOVE_DONE = 0;
   localparam int IRQ_SEQ_STOP = 1;
   localparam int IRQ_SERVO_OFF = 2;
   localparam logic [2:0] IRQ_RESET = 3'h0;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_MOVE = 3'b001,
      ST_WAIT = 3'b010,
      ST_STOPPING = 3'b011
   } cmps_state_type;
endpackage

// file: verilog/cmps_wait_if.sv
`timescale 1ns/1ns
interface cmps_wait_if;
   logic start;
   logic seconds;
   logic [15:0] length;
   logic done;
   modport seq(output start, output seconds, output length, input done);
   modport timer(input start, input seconds, input length, output done);
endinterface

// file: verilog/cmps_wait_timer.sv
`timescale 1ns/1ns
module cmps_wait_timer
   import cmps_pkg::*;
#(
   parameter int CYCLES_PER_MS = CYCLES_PER_MS_DEF
) (
   input wire logic i_clk,
   input wire logic i_reset,
   cmps_wait_if.timer wt
);
   logic busy;
   logic done;
   logic sec_q;
   logic [WAIT_W-1:0] len_q;
   logic [31:0] cyc_cnt;
   logic [9:0] ms_cnt;
   logic [WAIT_W-1:0] unit_cnt;

   assign wt.done = done;

   // ----------------------------------------------------------------
   // Wait counter
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         busy <= 1'b0;
         done <= 1'b0;
         sec_q <= 1'b0;
         len_q <= WAIT_RESET;
         cyc_cnt <= 32'h0000_0000;
         ms_cnt <= 10'h000;
         unit_cnt <= WAIT_RESET;
      end else begin
         done <= 1'b0;
         if (wt.start) begin
            busy <= (wt.length != WAIT_RESET);
            done <= (wt.length == WAIT_RESET);
            sec_q <= wt.seconds;
            len_q <= wt.length;
            cyc_cnt <= 32'h0000_0000;
            ms_cnt <= 10'h000;
            unit_cnt <= WAIT_RESET;
         end else if (busy) begin
            if (cyc_cnt == 32'(CYCLES_PER_MS - 1)) begin
               cyc_cnt <= 32'h0000_0000;
               // Seconds chain a further thousand ticks, see RULE_03
               if (!sec_q || ms_cnt == 10'(MS_PER_S - 1)) begin
                  ms_cnt <= 10'h000;
                  if (unit_cnt == len_q - 16'h0001) begin
                     busy <= 1'b0;
                     done <= 1'b1;
                  end else begin
                     unit_cnt <= unit_cnt + 16'h0001;
                  end
               end else begin
                  ms_cnt <= ms_cnt + 10'h001;
               end
            end else begin
               cyc_cnt <= cyc_cnt + 32'h0000_0001;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_ms_unit_only: assert property (@(posedge i_clk) disable iff (i_reset) // see RULE_03
      (busy && !sec_q) |-> ms_cnt == 10'h000)
      else $error("ms wait advanced the seconds counter");
endmodule

// file: verilog/cmps_sequencer.sv
// Behaviour
// RULE_01: Cyclic sequencing runs only while multi-position mode select equals 1.
// RULE_02: One cycle covers displacements one up to the displacement count setting.
// RULE_03: Wait time counts milliseconds when unit select is 0, seconds when 1.
// RULE_04: After the last displacement of a cycle, continue from displacement one.
// RULE_05: A finished displacement advances to the next one without host trigger.
// RULE_06: A configurable wait separates successive displacements.
// RULE_07: Cycles repeat endlessly while sequence enable stays asserted.
// RULE_08: Sequence enable acts on its level; host holds it while sequencing.
// RULE_09: Positioning done flag rises when each displacement finishes.
// RULE_10: Losing sequence enable mid-sequence drops remaining moves and stops motion.
// RULE_11: After such a stop, positioning done rises once motion has ceased.
// RULE_12: Re-enabling resumes as the restart behaviour setting selects.
// RULE_13: Servo-on loss stops via configured method; positioning done stays low.
// RULE_14: Direction select changes never alter a displacement in progress.
// RULE_15: Direction select is sampled at each displacement start and held.
//
// Local design decisions: register access over APB and the placing of the registers.
`timescale 1ns/1ns
module cmps_sequencer
   import cmps_pkg::*;
#(
   parameter int CYCLES_PER_MS = CYCLES_PER_MS_DEF
) (
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic i_sequence_enable_input,
   input wire logic i_servo_on,
   input wire logic i_direction_select_input,
   input wire logic i_move_done,
   input wire logic i_motion_stopped,
   output logic o_move_start,
   output logic [3:0] o_move_index,
   output logic o_move_dir,
   output logic o_stop_request,
   output logic o_servo_off_stop,
   output logic [1:0] o_servo_off_stop_method,
   output logic o_positioning_done_flag,
   output logic o_irq
);
   logic [31:0] ctrl;
   logic [WAIT_W-1:0] wait_len;
   logic [IRQ_W-1:0] irq_stat;
   logic [IRQ_W-1:0] irq_mask;
   logic [IRQ_W-1:0] irq_event;
   logic en_m;
   logic en_s;
   logic son_m;
   logic son_s;
   logic dir_m;
   logic dir_s;
   cmps_state_type st;
   logic [IDX_W-1:0] cur_idx;
   logic move_start;
   logic move_dir;
   logic done_flag;
   logic stop_req;
   logic soff_stop;
   logic wt_start;
   logic ev_move;
   logic ev_stop;
   logic ev_soff;
   logic [1:0] mode_sel;
   logic [COUNT_W-1:0] disp_count;
   logic restart_resume;
   logic cyc_mode;
   logic cnt_ok;
   logic [IDX_W-1:0] last_idx;
   logic [IDX_W-1:0] start_idx;
   logic setup_rd;
   logic acc_wr;
   logic mapped;
   logic [31:0] rd_mux;

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         en_m <= 1'b0;
         en_s <= 1'b0;
         son_m <= 1'b0;
         son_s <= 1'b0;
         dir_m <= 1'b0;
         dir_s <= 1'b0;
      end else begin
         en_m <= i_sequence_enable_input;
         en_s <= en_m;
         son_m <= i_servo_on;
         son_s <= son_m;
         dir_m <= i_direction_select_input;
         dir_s <= dir_m;
      end
   end

   // ----------------------------------------------------------------
   // Settings decode
   // ----------------------------------------------------------------
   assign mode_sel = ctrl[CTRL_MODE_LSB +: MODE_W];
   assign disp_count = ctrl[CTRL_COUNT_LSB +: COUNT_W];
   assign restart_resume = ctrl[CTRL_RESTART_BIT];
   assign cyc_mode = (mode_sel == MODE_CYCLIC); // see RULE_01
   assign cnt_ok = (disp_count != 5'h00) && (disp_count <= COUNT_MAX);
   assign last_idx = IDX_W'(disp_count - 5'h01); // see RULE_02
   assign start_idx = (restart_resume && cur_idx <= last_idx) ? cur_idx : '0; // see RULE_12

   // ----------------------------------------------------------------
   // Wait timer
   // ----------------------------------------------------------------
   cmps_wait_if wt_bus();
   assign wt_bus.start = wt_start;
   assign wt_bus.seconds = ctrl[CTRL_UNIT_BIT]; // see RULE_03
   assign wt_bus.length = wait_len;

   cmps_wait_timer #(
      .CYCLES_PER_MS(CYCLES_PER_MS)
   ) u_timer (
      .i_clk(i_clk),
      .i_reset(i_reset),
      .wt(wt_bus.timer)
   );

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         st <= ST_IDLE;
         cur_idx <= '0;
         move_start <= 1'b0;
         move_dir <= 1'b0;
         done_flag <= 1'b0;
         stop_req <= 1'b0;
         soff_stop <= 1'b0;
         wt_start <= 1'b0;
         ev_move <= 1'b0;
         ev_stop <= 1'b0;
         ev_soff <= 1'b0;
      end else begin
         move_start <= 1'b0;
         soff_stop <= 1'b0;
         wt_start <= 1'b0;
         ev_move <= 1'b0;
         ev_stop <= 1'b0;
         ev_soff <= 1'b0;
         case (st)
            ST_IDLE: begin
               // Level of enable, not its edge, starts a sequence, see RULE_08
               if (cyc_mode && en_s && son_s && cnt_ok) begin // see RULE_01
                  st <= ST_MOVE;
                  cur_idx <= start_idx; // see RULE_12
                  move_start <= 1'b1;
                  move_dir <= dir_s; // see RULE_14 and RULE_15
                  done_flag <= 1'b0;
               end
            end
            ST_MOVE: begin
               if (!son_s) begin
                  soff_stop <= 1'b1; // see RULE_13
                  done_flag <= 1'b0;
                  ev_soff <= 1'b1;
                  st <= ST_IDLE;
               end else if (!en_s) begin
                  stop_req <= 1'b1; // see RULE_10
                  st <= ST_STOPPING;
               end else if (i_move_done) begin
                  done_flag <= 1'b1; // see RULE_09
                  ev_move <= 1'b1;
                  // Wrap to the first displacement, see RULE_04
                  cur_idx <= (cur_idx >= last_idx) ? '0 : cur_idx + 4'h1;
                  wt_start <= 1'b1; // see RULE_06
                  st <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (!son_s) begin
                  soff_stop <= 1'b1; // see RULE_13
                  done_flag <= 1'b0;
                  ev_soff <= 1'b1;
                  st <= ST_IDLE;
               end else if (!en_s || !cyc_mode) begin
                  // Motor already at rest, remaining moves dropped, see RULE_10
                  ev_stop <= 1'b1;
                  st <= ST_IDLE;
               end else if (wt_bus.done) begin
                  // Next move with no host trigger, see RULE_05 and RULE_07
                  move_start <= 1'b1;
                  move_dir <= dir_s; // see RULE_15
                  done_flag <= 1'b0;
                  st <= ST_MOVE;
               end
            end
            ST_STOPPING: begin
               if (!son_s) begin
                  stop_req <= 1'b0;
                  soff_stop <= 1'b1; // see RULE_13
                  done_flag <= 1'b0;
                  ev_soff <= 1'b1;
                  st <= ST_IDLE;
               end else if (i_motion_stopped) begin
                  stop_req <= 1'b0;
                  done_flag <= 1'b1; // see RULE_11
                  ev_stop <= 1'b1;
                  st <= ST_IDLE;
               end
            end
            default: begin
               st <= ST_IDLE;
            end
         endcase
      end
   end

   assign o_move_start = move_start;
   assign o_move_index = cur_idx;
   assign o_move_dir = move_dir;
   assign o_stop_request = stop_req;
   assign o_servo_off_stop = soff_stop;
   assign o_servo_off_stop_method = ctrl[CTRL_STOPM_LSB +: STOPM_W];
   assign o_positioning_done_flag = done_flag;

   // ----------------------------------------------------------------
   // APB slave
   // ----------------------------------------------------------------
   assign setup_rd = i_psel && !i_penable && !i_pwrite;
   assign acc_wr = i_psel && i_penable && i_pwrite;
   assign mapped = (i_paddr == OFS_CTRL) || (i_paddr == OFS_WAIT) ||
      (i_paddr == OFS_STATUS) || (i_paddr == OFS_IRQ_STAT) || (i_paddr == OFS_IRQ_MASK);
   assign o_pready = 1'b1;
   assign o_pslverr = i_psel && i_penable && !mapped;

   always_comb begin
      rd_mux = 32'h0000_0000;
      case (i_paddr)
         OFS_CTRL: rd_mux = ctrl;
         OFS_WAIT: rd_mux[WAIT_W-1:0] = wait_len;
         OFS_STATUS: begin
            rd_mux[STAT_STATE_LSB +: 3] = st;
            rd_mux[STAT_IDX_LSB +: IDX_W] = cur_idx;
            rd_mux[STAT_DONE_BIT] = done_flag;
            rd_mux[STAT_DIR_BIT] = move_dir;
         end
         OFS_IRQ_STAT: rd_mux[IRQ_W-1:0] = irq_stat;
         OFS_IRQ_MASK: rd_mux[IRQ_W-1:0] = irq_mask;
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_prdata <= 32'h0000_0000;
      end else if (setup_rd) begin
         o_prdata <= rd_mux;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         ctrl <= CTRL_RESET;
         wait_len <= WAIT_RESET;
         irq_mask <= IRQ_RESET;
      end else if (acc_wr) begin
         if (i_paddr == OFS_CTRL) begin
            ctrl <= i_pwdata;
         end
         if (i_paddr == OFS_WAIT) begin
            wait_len <= i_pwdata[WAIT_W-1:0];
         end
         if (i_paddr == OFS_IRQ_MASK) begin
            irq_mask <= i_pwdata[IRQ_W-1:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Interrupts
   // ----------------------------------------------------------------
   assign irq_event[IRQ_MOVE_DONE] = ev_move;
   assign irq_event[IRQ_SEQ_STOP] = ev_stop;
   assign irq_event[IRQ_SERVO_OFF] = ev_soff;

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         irq_stat <= IRQ_RESET;
      end else if (acc_wr && i_paddr == OFS_IRQ_STAT) begin
         irq_stat <= (irq_stat & ~i_pwdata[IRQ_W-1:0]) | irq_event;
      end else begin
         irq_stat <= irq_stat | irq_event;
      end
   end

   assign o_irq = |(irq_stat & irq_mask);

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_mode_gates_start: assert property (@(posedge i_clk) disable iff (i_reset) // see RULE_01
      o_move_start |-> $past(cyc_mode))
      else $error("move started outside cyclic mode");

   a_index_in_count: assert property (@(posedge i_clk) disable iff (i_reset) // see RULE_02
      (o_move_start && $past(st) == ST_IDLE) |-> o_move_index <= $past(last_idx))
      else $error("move index beyond displacement count");

   a_wrap_to_first: assert property (@(posedge i_clk) disable iff (i_reset) // see RULE_04
      (st == ST_MOVE && son_s && en_s && i_move_done && cur_idx == last_idx)
      |=> cur_idx == '0)
      else $error("cycle did not wrap to first displacement");

   a_auto_advance: assert property (@(posedge i_clk) disable iff (i_reset) // see RULE_05
      (st == ST_WAIT && son_s && en_s && cyc_mode && wt_bus.done)
      |=> o_move_start && st == ST_MOVE)
      else $error("next displacement not started after wait");

   a_wait_between: assert property (@(posedge i_clk) disable iff (i_reset) // see RULE_06
      (st == ST_MOVE && son_s && en_s && i_move_done) |=> st == ST_WAIT ##0 $rose(wt_start))
      else $error("no wait after displacement");

   a_enable_loss_stop: assert property (@(posedge i_clk) disable iff (i_reset) // see RULE_10
      (st == ST_MOVE && son_s && !en_s) |=> o_stop_request && st == ST_STOPPING)
      else $error("enable loss did not request stop");

   a_done_each_move: assert property (@(posedge i_clk) disable iff (i_reset) // see RULE_09
      (st == ST_MOVE && son_s && en_s && i_move_done) |=> o_positioning_done_flag ##1 irq_stat[IRQ_MOVE_DONE])
      else $error("positioning done missing after displacement");

   a_done_after_stop: assert property (@(posedge i_clk) disable iff (i_reset) // see RULE_11
      (st == ST_STOPPING && son_s && i_motion_stopped)
      |=> o_positioning_done_flag && !o_stop_request && st == ST_IDLE)
      else $error("positioning done missing after stop");

   a_servo_off_stop: assert property (@(posedge i_clk) disable iff (i_reset) // see RULE_13
      (st != ST_IDLE && !son_s) |=> o_servo_off_stop && !o_positioning_done_flag)
      else $error("servo off not handled");

   a_dir_held: assert property (@(posedge i_clk) disable iff (i_reset) // see RULE_14
      (st == ST_MOVE && $past(st) == ST_MOVE) |-> $stable(o_move_dir))
      else $error("direction changed during displacement");
endmodule

// file: test/cmps_motion_model.sv
`timescale 1ns/1ns
module cmps_motion_model (
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_move_start,
   input wire logic i_abort,
   input wire logic i_stop_request,
   input wire logic [7:0] i_delay,
   output logic o_move_done,
   output logic o_motion_stopped
);
   // ---------------------------------------------
   // Trajectory stand-in, delays set per move
   // ---------------------------------------------
   int mcnt;
   int scnt;

   always @(posedge i_clk) begin
      o_move_done <= 1'b0;
      if (i_reset) begin
         mcnt <= 0;
         scnt <= 0;
         o_motion_stopped <= 1'b0;
      end else begin
         if (i_move_start) begin
            mcnt <= int'(i_delay);
         end else if (i_abort) begin
            mcnt <= 0;
         end else if (mcnt == 1) begin
            mcnt <= 0;
            o_move_done <= 1'b1;
         end else if (mcnt > 1) begin
            mcnt <= mcnt - 1;
         end
         if (!i_stop_request) begin
            scnt <= int'(i_delay);
            o_motion_stopped <= 1'b0;
         end else if (scnt == 0) begin
            o_motion_stopped <= 1'b1;
         end else begin
            scnt <= scnt - 1;
         end
      end
   end
endmodule

// file: test/cyclic_multi_position_sequencer_test.sv
`timescale 1ns/1ns
module cyclic_multi_position_sequencer_test;
   import cmps_pkg::*;
   localparam int CPMS = 4;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic en = 1'b0, servo = 1'b0, dir = 1'b0;
   logic [7:0] mdelay = 8'h08;
   logic [31:0] prdata, rd;
   logic pready, pslverr, err, move_done, motion_stopped, move_start, stop_req;
   logic srv_stop, done_flag, irq, move_dir, start_dir, md_d, st_d;
   logic [3:0] move_idx;
   logic [1:0] stop_m;
   logic [7:0] ofs [5] = '{OFS_CTRL, OFS_WAIT, OFS_STATUS, OFS_IRQ_STAT, OFS_IRQ_MASK};
   int num_errors = 0, checks = 0, seed = 32'h7df2;
   int starts = 0, exp_idx = 0, exp_gap = 0, count = 1, cyc = 0, done_cyc = -1;

   always #4 clk = ~clk;

   cmps_sequencer #(.CYCLES_PER_MS(CPMS)) i_cmps_sequencer (
      .i_clk(clk), .i_reset(reset), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(pslverr), .i_sequence_enable_input(en),
      .i_servo_on(servo), .i_direction_select_input(dir), .i_move_done(move_done),
      .i_motion_stopped(motion_stopped), .o_move_start(move_start),
      .o_move_index(move_idx), .o_move_dir(move_dir), .o_stop_request(stop_req),
      .o_servo_off_stop(srv_stop), .o_servo_off_stop_method(stop_m),
      .o_positioning_done_flag(done_flag), .o_irq(irq));

   cmps_motion_model i_cmps_motion_model (
      .i_clk(clk), .i_reset(reset), .i_move_start(move_start),
      .i_abort(stop_req | srv_stop), .i_stop_request(stop_req), .i_delay(mdelay),
      .o_move_done(move_done), .o_motion_stopped(motion_stopped));

   // ---------------------------------------------
   // Checking and bus tasks
   // ---------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic stop_test;
      $display("checks %0d num_errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && n < 50) begin
         @(posedge clk);
         n++;
      end
      check(pready, 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      check(rd & m, e);
   endtask

   task automatic wait_lvl(ref logic s, input logic v);
      int k;
      k = 0;
      while (s !== v && k < 200) begin
         @(posedge clk);
         k++;
      end
      check(s, v);
   endtask

   task automatic wait_starts(input int n);
      int k;
      k = 0;
      while (starts < n && k < 20000) begin
         @(posedge clk);
         k++;
      end
      if (starts < n) check(starts, n);
   endtask

   task automatic go(input logic [31:0] c, input logic [31:0] w, input int g, input int n,
                     input int i);
      apb(1'b1, OFS_CTRL, c);
      apb(1'b1, OFS_WAIT, w);
      exp_gap = g;
      count = n;
      exp_idx = i;
      done_cyc = -1;
      en <= 1'b1;
   endtask

   task automatic halt;
      int k;
      k = 0;
      en <= 1'b0;
      rd = 32'h0000_0001;
      while (rd[2:0] != 3'h0 && k < 100) begin
         apb(1'b0, OFS_STATUS, 32'h0000_0000);
         k++;
      end
      check(rd & 32'h0000_0007, 32'h0000_0000);
   endtask

   // ---------------------------------------------
   // Sequence model, compared at every move
   // ---------------------------------------------
   always @(posedge clk) begin
      cyc <= cyc + 1;
      md_d <= move_done;
      st_d <= move_start;
      if (md_d) check(done_flag, 1'b1);
      if (st_d) check(done_flag, 1'b0);
      if (move_done) begin
         check(move_dir, start_dir);
         done_cyc <= cyc;
      end
      if (move_start) begin
         starts <= starts + 1;
         check(move_idx, exp_idx);
         check(move_dir, dir);
         if (done_cyc >= 0) check(cyc - done_cyc >= exp_gap + 1 &&
                                  cyc - done_cyc <= exp_gap + 4, 1);
         start_dir <= move_dir;
         exp_idx <= (exp_idx + 1) % count;
         done_cyc <= -1;
         dir <= 1'($random(seed));
         mdelay <= 8'h08 + 8'($random(seed) & 7);
      end
   end

   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   initial begin
      int n;
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      servo <= 1'b1;
      foreach (ofs[k]) rdc(ofs[k], 32'hffff_ffff, 32'h0000_0000);
      apb(1'b0, 8'h14, 32'h0000_0000);
      check(err, 1'b1);
      check(rd, 32'h0000_0000);
      apb(1'b1, OFS_STATUS, 32'hffff_ffff);
      rdc(OFS_STATUS, 32'hffff_ffff, 32'h0000_0000);
      apb(1'b1, OFS_IRQ_MASK, 32'h0000_0007);
      for (int m = 0; m < 4; m++) begin
         if (m != 1) begin
            go(32'h0000_0300 | m, 32'h0000_0000, 0, 3, 0);
            repeat (40) @(posedge clk);
            check(starts, 0);
            halt();
         end
      end
      go(32'h0200_0301, 32'h0000_0002, 2 * CPMS, 3, 0);
      check(stop_m, 2'h2);
      wait_starts(starts + 7);
      rdc(OFS_IRQ_STAT, 32'h0000_0001, 32'h0000_0001);
      check(irq, 1'b1);
      halt();
      go(32'h0010_0201, 32'h0000_0001, MS_PER_S * CPMS, 2, 0);
      wait_starts(starts + 3);
      halt();
      apb(1'b1, OFS_IRQ_STAT, 32'h0000_0007);
      rdc(OFS_IRQ_STAT, 32'h0000_0007, 32'h0000_0000);
      check(irq, 1'b0);
      for (int r = 0; r < 2; r++) begin
         go(32'h0000_0401 | (r << 16), 32'h0000_0000, 0, 4, 0);
         wait_starts(starts + 2);
         en <= 1'b0;
         wait_lvl(stop_req, 1'b1);
         check(done_flag, 1'b0);
         wait_lvl(stop_req, 1'b0);
         check(done_flag, 1'b1);
         rdc(OFS_IRQ_STAT, 32'h0000_0002, 32'h0000_0002);
         n = starts;
         repeat (30) @(posedge clk);
         check(starts, n);
         exp_idx = r;
         en <= 1'b1;
         wait_starts(n + 1);
         halt();
      end
      apb(1'b1, OFS_IRQ_STAT, 32'h0000_0007);
      apb(1'b1, OFS_IRQ_MASK, 32'h0000_0000);
      go(32'h0000_0201, 32'h0000_0000, 0, 2, 0);
      wait_starts(starts + 1);
      servo <= 1'b0;
      wait_lvl(srv_stop, 1'b1);
      n = starts;
      repeat (30) @(posedge clk);
      check(done_flag, 1'b0);
      check(starts, n);
      rdc(OFS_IRQ_STAT, 32'h0000_0004, 32'h0000_0004);
      check(irq, 1'b0);
      apb(1'b1, OFS_IRQ_MASK, 32'h0000_0004);
      @(posedge clk);
      check(irq, 1'b1);
      stop_test();
   end

   initial begin
      #400000;
      check(1'b0, 1'b1);
      stop_test();
   end
endmodule
